// file: tcc_pkg.sv
// Constants, register map and field types for the 16-bit capture timer
package tcc_pkg;

  // Wishbone byte addresses, one aligned word per register
  localparam logic [5:0] TCC_OFS_CNT_HI  = 6'h00;
  localparam logic [5:0] TCC_OFS_CNT_LO  = 6'h04;
  localparam logic [5:0] TCC_OFS_ALT_HI  = 6'h08;
  localparam logic [5:0] TCC_OFS_ALT_LO  = 6'h0c;
  localparam logic [5:0] TCC_OFS_CAP1_HI = 6'h10;
  localparam logic [5:0] TCC_OFS_CAP1_LO = 6'h14;
  localparam logic [5:0] TCC_OFS_CAP2_HI = 6'h18;
  localparam logic [5:0] TCC_OFS_CAP2_LO = 6'h1c;
  localparam logic [5:0] TCC_OFS_STATUS  = 6'h20;
  localparam logic [5:0] TCC_OFS_CTRL1   = 6'h24;
  localparam logic [5:0] TCC_OFS_CTRL2   = 6'h28;

  localparam logic [15:0] TCC_CNT_RESET = 16'hfffc;
  localparam logic [15:0] TCC_CNT_MAX   = 16'hffff;
  localparam logic [7:0]  TCC_BYTE_ZERO = 8'h00;

  // Clock select codes
  localparam logic [1:0] TCC_CLK_DIV2 = 2'h0;
  localparam logic [1:0] TCC_CLK_DIV4 = 2'h1;
  localparam logic [1:0] TCC_CLK_DIV8 = 2'h2;
  localparam logic [1:0] TCC_CLK_EXT  = 2'h3;

  // Prescaler terminal counts for the three internal rates
  localparam logic [2:0] TCC_PRE_END2 = 3'h1;
  localparam logic [2:0] TCC_PRE_END4 = 3'h3;
  localparam logic [2:0] TCC_PRE_END8 = 3'h7;
  localparam logic [2:0] TCC_PRE_MSK2 = 3'h1;
  localparam logic [2:0] TCC_PRE_MSK4 = 3'h3;
  localparam logic [2:0] TCC_PRE_MSK8 = 3'h7;

  // Control one: bit7 overflow enable, bit6 capture enable, bit1 capture one edge
  typedef struct packed {
    logic       overflow_irq_enable;
    logic       capture_irq_enable;
    logic [3:0] unused;
    logic       capture_one_edge_select;
    logic       spare;
  } tcc_ctrl1_t;

  // Control two: bit5 pwm, bit4 one-pulse, bits3:2 clock select, bit1 ch2 edge, bit0 ext edge
  typedef struct packed {
    logic [1:0] unused;
    logic       pwm_select;
    logic       one_pulse_select;
    logic [1:0] clock_select_field;
    logic       capture_two_edge_select;
    logic       ext_clock_edge_select;
  } tcc_ctrl2_t;

  // Status: bit7 capture one flag, bit6 capture two flag, bit5 overflow flag
  localparam int TCC_ST_CAP1 = 7;
  localparam int TCC_ST_CAP2 = 6;
  localparam int TCC_ST_OVF  = 5;

endpackage

// file: tcc_timer.sv
// 16-bit free-running timer with overflow flag and two input-capture channels
// Function
// - Sixteen-bit up-counter, read by software as separate high and low bytes.
// - Main and alternate views of one count; alternate low read never clears overflow.
// - Writing either counter low byte reloads the counter with FFFCh at once.
// - Reset value is FFFCh in all modes; FFFCh is the only reload value.
// - Internal rate is clock divided by 2, 4 or 8 per clock select.
// - Clock select both ones takes the count clock from the external pin.
// - External edge select picks which external pin transition advances the count.
// - Counter updates are synchronised to the internal clock, prescaled or external.
// - High-byte read freezes the low byte until the low byte is read.
// - Low read without prior high read returns the live low byte.
// - Rolling from FFFFh to 0000h sets the overflow flag in every mode.
// - Overflow interrupt needs enable set and CPU mask clear, else stays pending.
// - Overflow clears after status read with flag set, then main low access.
// - Counter runs in wait, holds in halt, restarts from reset on reset.
// - Active capture pin edge copies the count into that channel's capture register.
// - Each channel has its own edge select; one shared capture interrupt enable.
// - Capture sets channel flag; interrupt when enabled and unmasked, else pending.
// - Capture flag clears after status read with flag set, then capture low access.
// - Capture high read blocks captures and flag setting until capture low read.
// - In one-pulse or PWM mode only capture channel two captures.
// - Capture pins always feed the timer; any active edge captures unless blocked.
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_clock_pin,
  input  wire logic        capture_pin_one,
  input  wire logic        capture_pin_two,
  input  wire logic        cpu_irq_mask,
  input  wire logic        halt_mode,
  output logic             timer_irq
);

  // Bus decode: a request is acted on once, in the cycle before ack
  logic        req;
  logic        rd;
  logic        wr;
  logic        lane0;
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd    = req & ~wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign wr    = req & wb_we_i & lane0;

  logic hit_cnt_hi, hit_cnt_lo, hit_alt_hi, hit_alt_lo, hit_st, hit_c1, hit_c2;
  logic hit_ic1_hi, hit_ic1_lo, hit_ic2_hi, hit_ic2_lo;
  assign hit_cnt_hi = wb_adr_i == TCC_OFS_CNT_HI;
  assign hit_cnt_lo = wb_adr_i == TCC_OFS_CNT_LO;
  assign hit_alt_hi = wb_adr_i == TCC_OFS_ALT_HI;
  assign hit_alt_lo = wb_adr_i == TCC_OFS_ALT_LO;
  assign hit_ic1_hi = wb_adr_i == TCC_OFS_CAP1_HI;
  assign hit_ic1_lo = wb_adr_i == TCC_OFS_CAP1_LO;
  assign hit_ic2_hi = wb_adr_i == TCC_OFS_CAP2_HI;
  assign hit_ic2_lo = wb_adr_i == TCC_OFS_CAP2_LO;
  assign hit_st     = wb_adr_i == TCC_OFS_STATUS;
  assign hit_c1     = wb_adr_i == TCC_OFS_CTRL1;
  assign hit_c2     = wb_adr_i == TCC_OFS_CTRL2;

  // Control registers
  tcc_ctrl1_t ctrl1_q;
  tcc_ctrl2_t ctrl2_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_q <= '0;
      ctrl2_q <= '0;
    end else begin
      if (wr && hit_c1) ctrl1_q <= tcc_ctrl1_t'(wb_dat_i[7:0]);
      if (wr && hit_c2) ctrl2_q <= tcc_ctrl2_t'(wb_dat_i[7:0]);
    end
  end

  // Pin synchronisers: stage one feeds stage two only, edges use stages two and three
  logic [2:0] ext_s_q;
  logic [2:0] cap1_s_q;
  logic [2:0] cap2_s_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s_q  <= '0;
      cap1_s_q <= '0;
      cap2_s_q <= '0;
    end else begin
      ext_s_q  <= {ext_s_q[1:0], ext_clock_pin};
      cap1_s_q <= {cap1_s_q[1:0], capture_pin_one};
      cap2_s_q <= {cap2_s_q[1:0], capture_pin_two};
    end
  end

  // Edge select high means rising edge
  logic ext_edge;
  assign ext_edge = ctrl2_q.ext_clock_edge_select ? (ext_s_q[1] & ~ext_s_q[2])
                                                  : (~ext_s_q[1] & ext_s_q[2]);

  // Prescaler; frozen in halt so counting resumes from the held state
  logic [2:0] pre_q;
  logic [2:0] pre_mask;
  logic [2:0] pre_end;
  logic       int_tick;
  logic       tick;
  logic       is_ext;
  assign is_ext   = ctrl2_q.clock_select_field == TCC_CLK_EXT;
  assign pre_mask = (ctrl2_q.clock_select_field == TCC_CLK_DIV2) ? TCC_PRE_MSK2 :
                    (ctrl2_q.clock_select_field == TCC_CLK_DIV4) ? TCC_PRE_MSK4 : TCC_PRE_MSK8;
  assign pre_end  = (ctrl2_q.clock_select_field == TCC_CLK_DIV2) ? TCC_PRE_END2 :
                    (ctrl2_q.clock_select_field == TCC_CLK_DIV4) ? TCC_PRE_END4 : TCC_PRE_END8;
  assign int_tick = (pre_q & pre_mask) == pre_end;
  // Both sources become one single-cycle tick of the core clock
  assign tick     = ~halt_mode & (is_ext ? ext_edge : int_tick);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pre_q <= '0;
    else if (!halt_mode) pre_q <= pre_q + 3'h1;
  end

  // Mode gating of channel one
  logic opm_active;
  logic wave_mode;
  assign wave_mode  = ctrl2_q.one_pulse_select | ctrl2_q.pwm_select;
  assign opm_active = ctrl2_q.one_pulse_select & ~ctrl2_q.pwm_select;

  // Capture channels
  logic [1:0]  cap_edge;
  logic [1:0]  cap_inh_q;
  logic [1:0]  cap_flag_q;
  logic [1:0]  cap_arm_q;
  logic [1:0]  cap_set;
  logic [1:0]  cap_load;
  logic [1:0]  cap_hi_rd;
  logic [1:0]  cap_lo_acc;
  logic [1:0]  cap_clr;
  logic [15:0] cap_val_q [2];
  logic [15:0] cnt_q;

  assign cap_edge[0] = ctrl1_q.capture_one_edge_select ? (cap1_s_q[1] & ~cap1_s_q[2])
                                                      : (~cap1_s_q[1] & cap1_s_q[2]);
  assign cap_edge[1] = ctrl2_q.capture_two_edge_select ? (cap2_s_q[1] & ~cap2_s_q[2])
                                                      : (~cap2_s_q[1] & cap2_s_q[2]);
  assign cap_hi_rd   = {rd & hit_ic2_hi, rd & hit_ic1_hi};
  assign cap_lo_acc  = {req & hit_ic2_lo, req & hit_ic1_lo};
  // Pins are never gated by direction; only a pending high read blocks channel two
  assign cap_set[1]  = cap_edge[1] & ~cap_inh_q[1];
  assign cap_load[1] = cap_set[1];
  // Channel one still flags in one-pulse mode but never loads its register
  assign cap_set[0]  = cap_edge[0] & ~cap_inh_q[0] & ~ctrl2_q.pwm_select;
  assign cap_load[0] = cap_edge[0] & ~cap_inh_q[0] & ~wave_mode;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      assign cap_clr[gi] = cap_lo_acc[gi] & cap_arm_q[gi];
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cap_inh_q[gi]  <= 1'b0;
          cap_flag_q[gi] <= 1'b0;
          cap_arm_q[gi]  <= 1'b0;
          cap_val_q[gi]  <= '0;
        end else begin
          if (cap_hi_rd[gi]) cap_inh_q[gi] <= 1'b1;
          else if (rd && cap_lo_acc[gi]) cap_inh_q[gi] <= 1'b0;
          // Set wins over a clear in the same cycle
          cap_flag_q[gi] <= cap_set[gi] | (cap_flag_q[gi] & ~cap_clr[gi]);
          if (rd && hit_st && cap_flag_q[gi]) cap_arm_q[gi] <= 1'b1;
          else if (cap_lo_acc[gi]) cap_arm_q[gi] <= 1'b0;
          if (cap_load[gi]) cap_val_q[gi] <= cnt_q;
        end
      end
    end
  endgenerate

  // Counter
  logic        reload;
  logic        ovf_set;
  logic [15:0] cnt_d;
  assign reload  = (wr & (hit_cnt_lo | hit_alt_lo)) | (opm_active & cap_set[0]);
  assign ovf_set = tick & (cnt_q == TCC_CNT_MAX) & ~reload;
  assign cnt_d   = reload ? TCC_CNT_RESET : (tick ? cnt_q + 16'h0001 : cnt_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= TCC_CNT_RESET;
    else cnt_q <= cnt_d;
  end

  // Overflow flag, cleared only by status read then main low access
  logic ovf_q;
  logic ovf_arm_q;
  logic ovf_clr;
  assign ovf_clr = req & hit_cnt_lo & ovf_arm_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q     <= 1'b0;
      ovf_arm_q <= 1'b0;
    end else begin
      ovf_q <= ovf_set | (ovf_q & ~ovf_clr);
      if (rd && hit_st && ovf_q) ovf_arm_q <= 1'b1;
      else if (req && hit_cnt_lo) ovf_arm_q <= 1'b0;
    end
  end

  // Shared low-byte buffer for both counter views
  logic       lo_lock_q;
  logic [7:0] lo_buf_q;
  logic       cnt_hi_rd;
  logic       cnt_lo_rd;
  logic [7:0] cnt_lo_view;
  assign cnt_hi_rd   = rd & (hit_cnt_hi | hit_alt_hi);
  assign cnt_lo_rd   = rd & (hit_cnt_lo | hit_alt_lo);
  assign cnt_lo_view = lo_lock_q ? lo_buf_q : cnt_q[7:0];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_lock_q <= 1'b0;
      lo_buf_q  <= '0;
    end else if (cnt_hi_rd && !lo_lock_q) begin
      lo_lock_q <= 1'b1;
      lo_buf_q  <= cnt_q[7:0];
    end else if (cnt_lo_rd) begin
      lo_lock_q <= 1'b0;
    end
  end

  // Read mux; flags are read-only, software cannot set them
  logic [7:0] status_view;
  logic [7:0] rd_byte;
  assign status_view = {cap_flag_q[0], cap_flag_q[1], ovf_q, 5'h00};
  assign rd_byte = hit_cnt_hi | hit_alt_hi ? cnt_q[15:8] :
                   hit_cnt_lo | hit_alt_lo ? cnt_lo_view :
                   hit_ic1_hi ? cap_val_q[0][15:8] :
                   hit_ic1_lo ? cap_val_q[0][7:0]  :
                   hit_ic2_hi ? cap_val_q[1][15:8] :
                   hit_ic2_lo ? cap_val_q[1][7:0]  :
                   hit_st     ? status_view :
                   hit_c1     ? 8'(ctrl1_q) :
                   hit_c2     ? 8'(ctrl2_q) : TCC_BYTE_ZERO;

  // Bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? {24'h000000, rd_byte} : '0;
    end
  end

  // One combined interrupt line; a masked request stays pending in its flag
  logic irq_d;
  assign irq_d = ~cpu_irq_mask & ((ovf_q & ctrl1_q.overflow_irq_enable) |
                 (|cap_flag_q & ctrl1_q.capture_irq_enable));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) timer_irq <= 1'b0;
    else timer_irq <= irq_d;
  end

  // Checks
  sequence s_hi_read;
    rd && hit_cnt_hi && !lo_lock_q;
  endsequence
  sequence s_status_armed;
    rd && hit_st && ovf_q;
  endsequence
  sequence s_cnt_lo_access;
    req && hit_cnt_lo && !ovf_set;
  endsequence
  sequence s_cap_armed;
    rd && hit_st && cap_flag_q[1];
  endsequence
  sequence s_cap_lo_access;
    req && hit_ic2_lo && !cap_set[1];
  endsequence

  cnt_reload_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr && hit_cnt_lo |=> cnt_q == TCC_CNT_RESET)
    else $error("counter not reloaded after low write");
  cnt_rollover_a: assert property (@(posedge clk) disable iff (!arst_n)
    tick && cnt_q == TCC_CNT_MAX && !reload |=> cnt_q == 16'h0000 && ovf_q)
    else $error("rollover did not set overflow");
  alt_keeps_ovf_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf_q && req && hit_alt_lo |=> ovf_q)
    else $error("alternate low access cleared overflow");
  halt_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    halt_mode && !reload |=> $stable(cnt_q))
    else $error("counter moved in halt");
  lo_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_hi_read ##1 (!cnt_lo_rd)[*2] |-> lo_buf_q == $past(cnt_q[7:0], 2))
    else $error("buffered low byte changed");
  ovf_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_status_armed ##[1:24] s_cnt_lo_access |=> !ovf_q)
    else $error("overflow not cleared by sequence");
  cap_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_cap_armed ##[1:24] s_cap_lo_access |=> !cap_flag_q[1])
    else $error("capture flag not cleared by sequence");
  cap_inhibit_a: assert property (@(posedge clk) disable iff (!arst_n)
    cap_inh_q[0] && !cap_flag_q[0] |=> !cap_flag_q[0] && $stable(cap_val_q[0]))
    else $error("inhibited channel captured");
  cap_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
    cap_set[1] |=> cap_val_q[1] == $past(cnt_q) && cap_flag_q[1])
    else $error("capture value not taken");
  wave_ch1_a: assert property (@(posedge clk) disable iff (!arst_n)
    wave_mode |=> $stable(cap_val_q[0]))
    else $error("channel one captured in waveform mode");
  irq_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf_q && ctrl1_q.overflow_irq_enable && !cpu_irq_mask |=> timer_irq)
    else $error("overflow interrupt not raised");
  irq_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_irq_mask |=> !timer_irq)
    else $error("interrupt raised while masked");
  alt_reload_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr && hit_alt_lo |=> cnt_q == TCC_CNT_RESET)
    else $error("counter not reloaded after alternate low write");
  cnt_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    tick && !reload |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not advance by one");
  cnt_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !tick && !reload |=> $stable(cnt_q))
    else $error("counter moved without a tick");
  lo_live_a: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_lo_rd && !lo_lock_q |=> wb_dat_o[7:0] == $past(cnt_q[7:0]))
    else $error("unbuffered low read not live");
  lo_buffered_a: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_lo_rd && lo_lock_q |=> wb_dat_o[7:0] == $past(lo_buf_q))
    else $error("buffered low read wrong");
  opm_reload_a: assert property (@(posedge clk) disable iff (!arst_n)
    opm_active && cap_set[0] |=> cnt_q == TCC_CNT_RESET)
    else $error("one-pulse trigger did not reload");
  st_read_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr && hit_st && !ovf_set |=> ovf_q == $past(ovf_q))
    else $error("status write changed overflow");
  cap_two_wave_a: assert property (@(posedge clk) disable iff (!arst_n)
    wave_mode && cap_set[1] |=> cap_flag_q[1])
    else $error("channel two blocked in waveform mode");
  ext_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    is_ext && !ext_edge |-> !tick)
    else $error("count advanced without external edge");
  irq_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
    |cap_flag_q && ctrl1_q.capture_irq_enable && !cpu_irq_mask |=> timer_irq)
    else $error("capture interrupt not raised");
  ovf_pending_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf_q && !(req && hit_cnt_lo) |=> ovf_q)
    else $error("overflow request lost");
  cap_flag_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    cap_flag_q[0] && !cap_lo_acc[0] |=> cap_flag_q[0])
    else $error("capture request lost");
  ovf_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(ovf_q) |-> $past(cnt_q) == TCC_CNT_MAX)
    else $error("overflow set without rollover");

endmodule

// file: tcc_cpu_model.sv
// CPU core model: classic Wishbone single-cycle master for the timer
module tcc_cpu_model
  import tcc_pkg::*;
(
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [5:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 4'h0;
    dat_w = 32'h00000000;
  end

  // Called just after a rising edge; holds the request until ack is sampled
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    q = 32'hxxxxxxxx;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat_w <= {24'h000000, d};
    // No latency assumed; only the bench watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released data no longer shows the old value
    dat_w <= ~dat_w;
    @(posedge clk);
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the 16-bit capture timer
module tb
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, arst_n, cyc, stb, we, ack, ext, cap1, cap2, mask, halt, irq;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr;
  logic [15:0] v, w;
  int          fail_count = 0;
  int          num_checks = 0;

  tcc_timer DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .ext_clock_pin(ext), .capture_pin_one(cap1), .capture_pin_two(cap2),
    .cpu_irq_mask(mask), .halt_mode(halt), .timer_irq(irq));
  tcc_cpu_model cpu (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dw), .dat_r(dr), .ack(ack));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    logic [31:0] q;
    cpu.xfer(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    cpu.xfer(1'b1, a, d, q);
  endtask

  // High byte first, then low byte of the same view
  task automatic rd16(input logic [5:0] a, output logic [15:0] r);
    logic [31:0] h, l;
    cpu.xfer(1'b0, a, 8'h00, h);
    cpu.xfer(1'b0, a + 6'h04, 8'h00, l);
    r = {h[7:0], l[7:0]};
  endtask

  // Halt gives exact counts; counter runs only while halt is low
  task automatic run(input int n);
    halt <= 1'b0;
    repeat (n) @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
  endtask

  task automatic t_reset();
    rdc(TCC_OFS_CNT_HI, 8'hff);
    rdc(TCC_OFS_CNT_LO, 8'hfc);
    rdc(TCC_OFS_ALT_HI, 8'hff);
    rdc(TCC_OFS_ALT_LO, 8'hfc);
    wr(TCC_OFS_STATUS, 8'hff);
    rdc(TCC_OFS_STATUS, 8'h00);
    rdc(6'h3c, 8'h00);
    chk({31'h0, irq}, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_rate();
    for (int i = 0; i < 3; i++) begin
      wr(TCC_OFS_CTRL2, {4'h0, 2'(i), 2'h0});
      wr(TCC_OFS_CNT_LO, 8'h00);
      run(64);
      rd16(TCC_OFS_CNT_HI, v);
      // Prescaler phase after reload is not pinned, so allow one count either way
      w = v - (TCC_CNT_RESET + 16'(64 >> (i + 1)));
      chk({31'h0, w inside {16'h0000, 16'h0001, 16'hffff}}, 32'h1);
    end
    $display("t_rate done");
  endtask

  task automatic t_ovf();
    wr(TCC_OFS_CTRL1, 8'h80);
    rdc(TCC_OFS_STATUS, 8'h20);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    mask <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd16(TCC_OFS_ALT_HI, v);
    rdc(TCC_OFS_STATUS, 8'h20);
    rd16(TCC_OFS_CNT_HI, v);
    rdc(TCC_OFS_STATUS, 8'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    mask <= 1'b1;
    $display("t_ovf done");
  endtask

  task automatic t_latch();
    wr(TCC_OFS_CTRL2, 8'h00);
    wr(TCC_OFS_ALT_LO, 8'h00);
    rdc(TCC_OFS_CNT_HI, 8'hff);
    run(12);
    rdc(TCC_OFS_CNT_HI, 8'h00);
    rdc(TCC_OFS_CNT_LO, 8'hfc);
    rd16(TCC_OFS_ALT_HI, v);
    chk({31'h0, v inside {[16'h0001:16'h0003]}}, 32'h1);
    rdc(TCC_OFS_ALT_LO, 8'h02);
    $display("t_latch done");
  endtask

  task automatic t_ext();
    for (int e = 1; e >= 0; e--) begin
      ext <= 1'b0;
      repeat (8) @(posedge clk);
      wr(TCC_OFS_CTRL2, {6'h03, 1'b0, 1'(e)});
      wr(TCC_OFS_CNT_LO, 8'h00);
      halt <= 1'b0;
      // Eight clocks between pin edges keeps the source slow enough
      for (int k = 0; k < 5; k++) begin
        ext <= 1'b1;
        repeat (8) @(posedge clk);
        if (k < 4) ext <= 1'b0;
        repeat (8) @(posedge clk);
      end
      halt <= 1'b1;
      @(posedge clk);
      rd16(TCC_OFS_CNT_HI, v);
      chk({16'h0, v}, {16'h0, TCC_CNT_RESET + 16'(4 + e)});
    end
    $display("t_ext done");
  endtask

  task automatic t_cap();
    wr(TCC_OFS_CTRL2, 8'h00);
    // Earlier runs rolled over; clear the overflow so status shows captures only
    rdc(TCC_OFS_STATUS, 8'h20);
    wr(TCC_OFS_CNT_LO, 8'h00);
    wr(TCC_OFS_CTRL1, 8'h42);
    mask <= 1'b0;
    cap1 <= 1'b1;
    cap2 <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(TCC_OFS_STATUS, 8'hc0);
    chk({31'h0, irq}, 32'h1);
    rd16(TCC_OFS_CAP1_HI, v);
    chk({16'h0, v}, {16'h0, TCC_CNT_RESET});
    rd16(TCC_OFS_CAP2_HI, v);
    chk({16'h0, v}, {16'h0, TCC_CNT_RESET});
    rdc(TCC_OFS_STATUS, 8'h00);
    rdc(TCC_OFS_CAP1_HI, 8'hff);
    run(4);
    cap1 <= 1'b0;
    repeat (4) @(posedge clk);
    cap1 <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(TCC_OFS_STATUS, 8'h00);
    rdc(TCC_OFS_CAP1_LO, 8'hfc);
    cap1 <= 1'b0;
    repeat (4) @(posedge clk);
    cap1 <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(TCC_OFS_STATUS, 8'h80);
    rd16(TCC_OFS_ALT_HI, w);
    rd16(TCC_OFS_CAP1_HI, v);
    chk({16'h0, v}, {16'h0, w});
    wr(TCC_OFS_CTRL2, 8'h10);
    cap2 <= 1'b1;
    repeat (6) @(posedge clk);
    cap2 <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(TCC_OFS_STATUS, 8'h40);
    cap1 <= 1'b0;
    repeat (4) @(posedge clk);
    cap1 <= 1'b1;
    repeat (6) @(posedge clk);
    rd16(TCC_OFS_ALT_HI, v);
    chk({16'h0, v}, {16'h0, TCC_CNT_RESET});
    rd16(TCC_OFS_CAP1_HI, v);
    chk({16'h0, v}, {16'h0, w});
    $display("t_cap done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    arst_n = 1'b0;
    halt = 1'b1;
    mask = 1'b1;
    ext = 1'b0;
    cap1 = 1'b0;
    cap2 = 1'b1;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_rate();
    t_ovf();
    t_latch();
    t_ext();
    t_cap();
    end_of_test();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
endmodule
